//--- rtl/pers_pkg.sv
// constants and carrier types for the enable and reset supervisor
package pers_pkg;

  // clock and documented times
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_MS    = 50;
  localparam int unsigned RESET_DELAY_MS = 100;
  localparam int unsigned DEBOUNCE_CYC   = CYC_PER_MS * DEBOUNCE_MS;
  localparam int unsigned RESET_DLY_CYC  = CYC_PER_MS * RESET_DELAY_MS;
  localparam int          CNT_W          = 24;

  // apb decode: index is the word address
  localparam int AW      = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // register indices
  localparam logic [7:0] IDX_CHG_CFG2  = 8'h04;
  localparam logic [7:0] IDX_CHG_CFG3  = 8'h05;
  localparam logic [7:0] IDX_BUCK_V    = 8'h07;
  localparam logic [7:0] IDX_LINREG_V  = 8'h08;
  localparam logic [7:0] IDX_MISC_CTRL = 8'h0A;
  localparam logic [7:0] IDX_GPIO_DATA = 8'h0B;
  localparam logic [7:0] IDX_GPIO_DIR  = 8'h0C;
  localparam logic [7:0] IDX_IRQ_MASK0 = 8'h0D;
  localparam logic [7:0] IDX_IRQ_FLAG0 = 8'h0E;

  // field positions
  localparam int HOLD_BIT     = 7;
  localparam int MISC_HOLDALL = 5;
  localparam int MISC_MON_SEL = 0;
  localparam int MISC_MON_EN  = 1;
  localparam int CFG2_CMP_EN  = 0;
  localparam int CFG2_CHG_EN  = 1;
  localparam int CFG3_CMP     = 0;
  localparam int CFG3_SEL_LO  = 1;
  localparam int CFG3_SEL_HI  = 2;
  localparam int IRQ_CELL_LOW = 0;
  localparam int VCODE_MSB    = 5;

  // voltage code 0 is 0.8 V, steps of 50 mV, top code is 3.3 V
  localparam logic [5:0] VCODE_MAX = 6'h32;

  // reset values
  localparam logic [7:0] CFG2_RST  = 8'h02;
  localparam logic [7:0] CFG3_RST  = 8'h01;
  localparam logic [7:0] MISC_RST  = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'hFF;
  localparam logic [3:0] GDIR_RST  = 4'hC;
  localparam logic [3:0] GDATA_RST = 4'h0;

  typedef struct packed {
    logic       push_button_n;
    logic       buck_hold_in;
    logic       linreg_hold_in;
    logic       charger_input_good;
    logic       rail_uvlo;
    logic       linreg_pgood;
    logic       thr_below;
    logic       linreg_overtemp;
    logic       chg_overtemp;
    logic       chg_overhot;
    logic       cell_below;
    logic       chg_active;
    logic       cell_present;
    logic [3:0] gpio_in;
  } pers_pins_s;

  typedef struct packed {
    logic       buck_enable;
    logic       linreg_enable;
    logic       ctrl_powered;
    logic       linreg_tmon_en;
    logic [5:0] buck_vsel;
    logic [5:0] linreg_vsel;
    logic       chg_current_reduce;
    logic       chg_disable;
    logic       mon_sel_temp;
    logic       mon_ground;
    logic       therm_bias_en;
    logic       cell_cmp_en;
    logic [1:0] cell_thr_sel;
    logic       reset_n_o;
    logic       reset_n_oe;
    logic       irq_n_o;
    logic       irq_n_oe;
    logic [3:0] gpio_sink_en;
  } pers_power_s;

  typedef struct packed {
    pers_pins_s       s1;
    pers_pins_s       s2;
    logic             pb_db;
    logic [CNT_W-1:0] db_cnt;
    logic             armed;
    logic             lost;
    logic             tsd;
    logic [CNT_W-1:0] rcnt;
    logic [7:0]       buck_v;
    logic [7:0]       linreg_v;
    logic [7:0]       misc;
    logic [7:0]       cfg2;
    logic [7:0]       cfg3;
    logic [7:0]       mask;
    logic [7:0]       flags;
    logic [3:0]       gdir;
    logic [3:0]       gdata;
    logic             pready;
    logic [31:0]      prdata;
    pers_power_s      out;
  } pers_state_s;

endpackage

//--- rtl/pers_supervisor.sv
// enable sequencing, reset supervision and apb control registers
`timescale 1ns/10ps
`default_nettype none

module pers_supervisor #(
  parameter int unsigned DEBOUNCE_CYCLES = pers_pkg::DEBOUNCE_CYC,
  parameter int unsigned RESET_DLY_CYCLES = pers_pkg::RESET_DLY_CYC,
  parameter bit          EXT_ADJ_BUCK = 1'b0,
  parameter bit          EXT_ADJ_LINREG = 1'b0,
  parameter bit          THRESHOLD_VARIANT = 1'b0,
  parameter logic [5:0]  BUCK_VDEF = 6'h16,
  parameter logic [5:0]  LINREG_VDEF = 6'h15
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [pers_pkg::AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  input  wire pers_pkg::pers_pins_s  pins,
  output pers_pkg::pers_power_s      power
);

  localparam logic [pers_pkg::CNT_W-1:0] DB_LAST =
    pers_pkg::CNT_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [pers_pkg::CNT_W-1:0] RD_LAST =
    pers_pkg::CNT_W'(RESET_DLY_CYCLES - 1);

  pers_pkg::pers_state_s st;
  pers_pkg::pers_state_s next_st;

  logic       pressed;
  logic       in_good;
  logic       gate_off;
  logic       common_on;
  logic       rcond;
  logic       reload;
  logic       acc;
  logic       setup;
  logic       cmp_active;
  logic [7:0] idx;

  // clamp a voltage code into the legal range, hold bit kept
  function automatic logic [7:0] vclamp(input logic [7:0] d);
    logic [5:0] c;
    c = d[pers_pkg::VCODE_MSB:0];
    if (c > pers_pkg::VCODE_MAX) begin
      c = pers_pkg::VCODE_MAX;
    end
    return {d[pers_pkg::HOLD_BIT], 1'b0, c};
  endfunction

  // read view of a register index, unmapped reads zero
  function automatic logic [7:0] rdval(input logic [7:0] i,
                                       input pers_pkg::pers_state_s s);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      pers_pkg::IDX_CHG_CFG2:  v = s.cfg2;
      pers_pkg::IDX_CHG_CFG3:  v = s.cfg3;
      pers_pkg::IDX_BUCK_V:    v = s.buck_v;
      pers_pkg::IDX_LINREG_V:  v = s.linreg_v;
      pers_pkg::IDX_MISC_CTRL: v = s.misc;
      pers_pkg::IDX_GPIO_DATA:
        v = {4'h0, (s.gdir & s.gdata) | (~s.gdir & s.s2.gpio_in)};
      pers_pkg::IDX_GPIO_DIR:  v = {4'h0, s.gdir};
      pers_pkg::IDX_IRQ_MASK0: v = s.mask;
      pers_pkg::IDX_IRQ_FLAG0: v = s.flags;
      default:                 v = 8'h00;
    endcase
    return v;
  endfunction

  // decoded helpers from registered state; setup, acc and idx also take the apb inputs directly
  assign pressed   = !st.pb_db;
  assign in_good   = st.s2.charger_input_good;
  assign gate_off  = st.s2.rail_uvlo | st.tsd;
  assign common_on = pressed | in_good | st.misc[pers_pkg::MISC_HOLDALL];
  assign reload    = st.s2.rail_uvlo | st.out.reset_n_oe;
  assign setup     = psel & !penable;
  assign acc       = psel & penable & st.pready;
  assign idx       = paddr[pers_pkg::IDX_MSB:pers_pkg::IDX_LSB];
  assign cmp_active = st.cfg2[pers_pkg::CFG2_CMP_EN] &
                      !st.cfg2[pers_pkg::CFG2_CHG_EN];
  // reset source depends on the variant strap
  assign rcond = THRESHOLD_VARIANT ? st.s2.thr_below :
                 (!st.s2.linreg_pgood | !st.out.linreg_enable);

  // whole next state
  always_comb begin
    next_st = st;
    // pins cross in through two flops
    next_st.s1 = pins;
    next_st.s2 = st.s1;

    // a level must hold for the whole period to be taken
    if (st.s2.push_button_n == st.pb_db) begin
      next_st.db_cnt = '0;
    end else if (st.db_cnt == DB_LAST) begin
      next_st.pb_db  = st.s2.push_button_n;
      next_st.db_cnt = '0;
    end else begin
      next_st.db_cnt = st.db_cnt + 1'b1;
    end

    // holds act as enables only after a first power-up
    if (!st.s2.cell_present) begin
      next_st.lost  = 1'b1;
      next_st.armed = 1'b0;
    end else if (pressed) begin
      next_st.lost  = 1'b0;
      next_st.armed = 1'b1;
    end else if (in_good && !st.lost) begin
      next_st.armed = 1'b1;
    end

    // trip latches until the sensor cools
    if (st.out.linreg_enable && st.s2.linreg_overtemp) begin
      next_st.tsd = 1'b1;
    end else if (!st.s2.linreg_overtemp) begin
      next_st.tsd = 1'b0;
    end

    // one gate for both rails so they drop in the same cycle
    next_st.out.buck_enable = !gate_off & (common_on |
      (st.armed & (st.s2.buck_hold_in | st.buck_v[pers_pkg::HOLD_BIT])));
    next_st.out.linreg_enable = !gate_off & (common_on |
      (st.armed & (st.s2.linreg_hold_in | st.linreg_v[pers_pkg::HOLD_BIT])));
    next_st.out.ctrl_powered = next_st.out.buck_enable |
                               next_st.out.linreg_enable;
    next_st.out.linreg_tmon_en = next_st.out.linreg_enable;

    // charger: reduce first, disable only once already reducing
    next_st.out.chg_current_reduce = st.s2.chg_overtemp;
    if (st.out.chg_current_reduce && st.s2.chg_overhot) begin
      next_st.out.chg_disable = 1'b1;
    end else if (!st.s2.chg_overtemp) begin
      next_st.out.chg_disable = 1'b0;
    end

    // reset delay restarts whenever the condition returns
    if (rcond) begin
      next_st.out.reset_n_oe = 1'b1;
      next_st.rcnt = '0;
    end else if (st.out.reset_n_oe) begin
      if (st.rcnt == RD_LAST) begin
        next_st.out.reset_n_oe = 1'b0;
      end else begin
        next_st.rcnt = st.rcnt + 1'b1;
      end
    end

    // register writes take effect at the access edge
    if (acc && pwrite) begin
      unique case (idx)
        pers_pkg::IDX_CHG_CFG2:  next_st.cfg2 = pwdata[7:0];
        pers_pkg::IDX_CHG_CFG3:
          next_st.cfg3 = {pwdata[7:1], st.cfg3[pers_pkg::CFG3_CMP]};
        pers_pkg::IDX_BUCK_V:    next_st.buck_v = vclamp(pwdata[7:0]);
        pers_pkg::IDX_LINREG_V:  next_st.linreg_v = vclamp(pwdata[7:0]);
        pers_pkg::IDX_MISC_CTRL: next_st.misc = pwdata[7:0];
        pers_pkg::IDX_GPIO_DATA: next_st.gdata = pwdata[3:0];
        pers_pkg::IDX_GPIO_DIR:  next_st.gdir = pwdata[3:0];
        pers_pkg::IDX_IRQ_MASK0: next_st.mask = pwdata[7:0];
        default: ;
      endcase
    end

    // defaults win over software while held down
    if (reload) begin
      next_st.buck_v   = {2'b00, BUCK_VDEF};
      next_st.linreg_v = {2'b00, LINREG_VDEF};
      next_st.cfg2     = pers_pkg::CFG2_RST;
      next_st.cfg3     = pers_pkg::CFG3_RST;
      next_st.misc     = pers_pkg::MISC_RST;
      next_st.mask     = pers_pkg::MASK_RST;
      next_st.gdir     = pers_pkg::GDIR_RST;
      next_st.gdata    = pers_pkg::GDATA_RST;
    end

    // comparator status, forced high when switched off
    if (!next_st.cfg2[pers_pkg::CFG2_CMP_EN]) begin
      next_st.cfg3[pers_pkg::CFG3_CMP] = 1'b1;
    end else if (cmp_active) begin
      next_st.cfg3[pers_pkg::CFG3_CMP] = !st.s2.cell_below;
    end

    // clear only the bits the read returned, a new event still lands
    if (acc && !pwrite && idx == pers_pkg::IDX_IRQ_FLAG0) begin
      next_st.flags = st.flags & ~st.prdata[7:0];
    end
    if (cmp_active && st.cfg3[pers_pkg::CFG3_CMP] &&
        !next_st.cfg3[pers_pkg::CFG3_CMP] &&
        !st.mask[pers_pkg::IRQ_CELL_LOW]) begin
      next_st.flags[pers_pkg::IRQ_CELL_LOW] = 1'b1;
    end
    next_st.out.irq_n_oe = |next_st.flags;

    // apb: data captured in setup, answered in first access cycle
    next_st.pready = setup;
    next_st.prdata = (setup && !pwrite) ? {24'h000000, rdval(idx, st)} : 32'h0;

    // analog steering and pin drives
    next_st.out.mon_sel_temp = st.misc[pers_pkg::MISC_MON_SEL];
    next_st.out.mon_ground = !st.misc[pers_pkg::MISC_MON_EN];
    next_st.out.therm_bias_en = !st.s2.chg_active &
      st.misc[pers_pkg::MISC_MON_EN] & st.misc[pers_pkg::MISC_MON_SEL];
    next_st.out.cell_cmp_en = cmp_active;
    next_st.out.cell_thr_sel = {st.cfg3[pers_pkg::CFG3_SEL_HI],
                                st.cfg3[pers_pkg::CFG3_SEL_LO]};
    next_st.out.gpio_sink_en = st.gdir & st.gdata;
    // adjustable parts keep the default code on the pins
    next_st.out.buck_vsel = EXT_ADJ_BUCK ? BUCK_VDEF :
      st.buck_v[pers_pkg::VCODE_MSB:0];
    next_st.out.linreg_vsel = EXT_ADJ_LINREG ? LINREG_VDEF :
      st.linreg_v[pers_pkg::VCODE_MSB:0];
    next_st.out.reset_n_o = 1'b0;
    next_st.out.irq_n_o = 1'b0;
  end

  // state register, reset holds the rails off and reset asserted
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      // pins start at their idle level so no false event follows reset
      st.s1.push_button_n <= 1'b1;
      st.s2.push_button_n <= 1'b1;
      st.s1.cell_present  <= 1'b1;
      st.s2.cell_present  <= 1'b1;
      st.pb_db <= 1'b1;
      st.buck_v <= {2'b00, BUCK_VDEF};
      st.linreg_v <= {2'b00, LINREG_VDEF};
      st.cfg2 <= pers_pkg::CFG2_RST;
      st.cfg3 <= pers_pkg::CFG3_RST;
      st.misc <= pers_pkg::MISC_RST;
      st.mask <= pers_pkg::MASK_RST;
      st.gdir <= pers_pkg::GDIR_RST;
      st.gdata <= pers_pkg::GDATA_RST;
      st.out.reset_n_oe <= 1'b1;
      st.out.mon_ground <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign power  = st.out;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_tsd_trip;
    st.out.linreg_enable && st.s2.linreg_overtemp;
  endsequence

  sequence s_both_off;
    !st.out.buck_enable && !st.out.linreg_enable;
  endsequence

  sequence s_cell_event;
    cmp_active && st.cfg3[pers_pkg::CFG3_CMP] && st.s2.cell_below &&
    !st.mask[pers_pkg::IRQ_CELL_LOW] && !reload && !(acc && pwrite);
  endsequence

  chk_uvlo_off: assert property (
    st.s2.rail_uvlo |=> s_both_off)
    else $error("rail on during lockout");
  chk_tsd_both: assert property (
    s_tsd_trip |=> st.tsd ##1 s_both_off)
    else $error("thermal trip did not drop both rails");
  chk_reset_hold: assert property (
    rcond |=> st.out.reset_n_oe)
    else $error("reset not asserted on condition");
  chk_reset_delay: assert property (
    $fell(st.out.reset_n_oe) |-> $past(st.rcnt) == RD_LAST && !$past(rcond))
    else $error("reset released early");
  chk_reload_def: assert property (
    st.out.reset_n_oe |=> st.buck_v == {2'b00, BUCK_VDEF})
    else $error("defaults not reloaded");
  chk_mon_ground: assert property (
    !st.misc[pers_pkg::MISC_MON_EN] |=> st.out.mon_ground)
    else $error("monitor not grounded");
  chk_bias_auto: assert property (
    (!st.s2.chg_active && st.misc[pers_pkg::MISC_MON_EN] &&
     st.misc[pers_pkg::MISC_MON_SEL]) |=> st.out.therm_bias_en)
    else $error("bias not enabled");
  chk_cmp_off: assert property (
    !st.cfg2[pers_pkg::CFG2_CMP_EN] |-> st.cfg3[pers_pkg::CFG3_CMP])
    else $error("status not high when disabled");
  chk_irq_drive: assert property (
    (|st.flags) |-> st.out.irq_n_oe)
    else $error("interrupt not driven");
  chk_hold_all: assert property (
    (st.misc[pers_pkg::MISC_HOLDALL] && !gate_off) |=>
      st.out.buck_enable && st.out.linreg_enable)
    else $error("hold bit ignored");
  chk_debounce_len: assert property (
    $changed(st.pb_db) |-> $past(st.db_cnt) == DB_LAST)
    else $error("debounce too short");

  // enables, holds and register side effects
  chk_press_on: assert property (
    ((pressed || in_good) && !gate_off) |=> st.out.buck_enable && st.out.linreg_enable)
    else $error("press did not enable rails");
  chk_release_off: assert property (
    (!common_on && !st.s2.buck_hold_in && !st.s2.linreg_hold_in &&
     !st.buck_v[pers_pkg::HOLD_BIT] && !st.linreg_v[pers_pkg::HOLD_BIT]) |=> s_both_off)
    else $error("rails left on without a hold");
  chk_buck_hold: assert property (
    (st.armed && st.s2.buck_hold_in && !gate_off) |=> st.out.buck_enable)
    else $error("buck hold ignored");
  chk_linreg_hold: assert property (
    (st.armed && st.s2.linreg_hold_in && !gate_off) |=> st.out.linreg_enable)
    else $error("regulator hold ignored");
  chk_debounce_restart: assert property (
    (st.s2.push_button_n == st.pb_db) |=> st.db_cnt == '0)
    else $error("debounce count not restarted");
  chk_chg_order: assert property (
    $rose(st.out.chg_disable) |-> $past(st.out.chg_current_reduce))
    else $error("charger disabled before reducing");
  chk_cell_irq: assert property (
    s_cell_event |=> st.flags[pers_pkg::IRQ_CELL_LOW] && st.out.irq_n_oe)
    else $error("cell low event not flagged");
  chk_flag_clear: assert property (
    (acc && !pwrite && idx == pers_pkg::IDX_IRQ_FLAG0 && !st.cfg3[pers_pkg::CFG3_CMP]) |=>
      (st.flags & $past(st.prdata[7:0])) == 8'h00)
    else $error("read flag not cleared");
  chk_gpio_reset: assert property (
    reload |=> st.gdir == pers_pkg::GDIR_RST && st.gdata == pers_pkg::GDATA_RST)
    else $error("gpio defaults not loaded");
  chk_uvlo_reload: assert property (
    st.s2.rail_uvlo |=> st.linreg_v == {2'b00, LINREG_VDEF} && st.misc == pers_pkg::MISC_RST)
    else $error("lockout did not reload defaults");
  chk_clamp_code: assert property (
    st.buck_v[pers_pkg::VCODE_MSB:0] <= pers_pkg::VCODE_MAX &&
    st.linreg_v[pers_pkg::VCODE_MSB:0] <= pers_pkg::VCODE_MAX)
    else $error("voltage code out of range");

endmodule // pers_supervisor

`default_nettype wire

//--- test/pers_button_model.sv
// push button model with contact chatter on every change
`timescale 1ns/10ps
`default_nettype none

module pers_button_model (
  input  wire logic       ref_clk,
  input  wire logic       press,
  input  wire logic [3:0] bounce,
  output logic            push_button_n
);
  logic       last = 1'b0;
  logic [3:0] left = 4'h0;

  // contacts chatter for bounce cycles, so debounce must restart each time
  always @(posedge ref_clk) begin
    if (press != last) begin
      last <= press;
      left <= bounce;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      push_button_n <= ~push_button_n;
    end else begin
      push_button_n <= ~press;
    end
  end
endmodule // pers_button_model
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the enable and reset supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c, n) begin wcnt = 0; \
  while (!(c) && wcnt < n) begin @(posedge ref_clk); wcnt++; end end

module testbench;
  localparam int unsigned DEB  = 20;
  localparam int unsigned RDLY = 30;
  logic                  ref_clk = 1'b0;
  logic                  reset   = 1'b1;
  logic                  psel    = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite  = 1'b0;
  logic [11:0]           paddr   = 12'h000;
  logic [31:0]           pwdata  = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  press   = 1'b0;
  logic [3:0]            bounce  = 4'h0;
  logic                  pb_n;
  pers_pkg::pers_pins_s  pins_tb;
  pers_pkg::pers_pins_s  pins;
  pers_pkg::pers_power_s power;
  logic [31:0]           prdata_thr;
  logic                  pready_thr;
  pers_pkg::pers_power_s power_thr;
  int                    n_fail = 0;
  int                    comparisons = 0;
  int                    wcnt;
  int                    tcnt = 0;
  // reset values: index, expected byte; last row is unmapped
  logic [15:0] rrow [8] = '{16'h0402, 16'h0501, 16'h0716, 16'h0815,
                            16'h0A00, 16'h0C0C, 16'h0DFF, 16'h2000};
  // monitor rows: sel,ground,bias expected; charger active; misc bits
  logic [7:0]  mrow [5] = '{8'h40, 8'hC1, 8'h02, 8'hA3, 8'h93};

  always #5 ref_clk = ~ref_clk;

  // button comes from the model, everything else from the bench
  always_comb begin
    pins = pins_tb;
    pins.push_button_n = pb_n;
  end

  pers_button_model btn (.ref_clk(ref_clk), .press(press), .bounce(bounce),
                         .push_button_n(pb_n));

  pers_supervisor #(.DEBOUNCE_CYCLES(DEB), .RESET_DLY_CYCLES(RDLY)) dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pins(pins), .power(power));

  // threshold variant with an externally adjusted buck shares every input
  pers_supervisor #(.DEBOUNCE_CYCLES(DEB), .RESET_DLY_CYCLES(RDLY), .EXT_ADJ_BUCK(1'b1),
                    .THRESHOLD_VARIANT(1'b1)) dut_thr (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_thr),
    .pready(pready_thr), .pins(pins), .power(power_thr));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait ends when pready is seen high; the bench hang guard is the only limit on it
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    apb(1'b1, idx, d, rd);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] rd;
    apb(1'b0, idx, 8'h00, rd);
    `CHK(nm, {24'h0, e}, rd)
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    tcnt <= tcnt + 1;
    if (tcnt == 6000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    pins_tb = '0;
    pins_tb.cell_present = 1'b1;
    pins_tb.linreg_pgood = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    `CHK("idle", 4'h6, {power.buck_enable, power.reset_n_oe, power.mon_ground, power.irq_n_oe})
    `CHK("gpio sinks off", 4'h0, power.gpio_sink_en)
    foreach (rrow[i]) rdchk("reset value", rrow[i][15:8], rrow[i][7:0]);
    wr(pers_pkg::IDX_BUCK_V, 8'h20);
    rdchk("write during reload", pers_pkg::IDX_BUCK_V, 8'h16);
    tdone("reset");
    // chattering press: rails must wait a full quiet period
    bounce <= 4'h8;
    press <= 1'b1;
    cyc(26);
    `CHK("early rail", 1'b0, power.buck_enable)
    `WAITC(power.buck_enable, 20)
    `CHK("rails up", 4'hF, {power.buck_enable, power.linreg_enable, power.ctrl_powered, power.linreg_tmon_en})
    cyc(25);
    `CHK("reset held", 1'b1, power.reset_n_oe)
    `WAITC(!power.reset_n_oe, 20)
    `CHK("reset released", 1'b0, power.reset_n_oe)
    tdone("power up");
    wr(pers_pkg::IDX_BUCK_V, 8'h3F);
    rdchk("buck clamp", pers_pkg::IDX_BUCK_V, 8'h32);
    `CHK("buck code", 6'h32, power.buck_vsel)
    `CHK("ext adjust code", 6'h16, power_thr.buck_vsel)
    for (int i = 0; i < 5; i++) begin
      pins_tb.chg_active <= mrow[i][4];
      wr(pers_pkg::IDX_MISC_CTRL, {6'h00, mrow[i][1:0]});
      cyc(4);
      `CHK("monitor", mrow[i][7:5], {power.mon_sel_temp, power.mon_ground, power.therm_bias_en})
    end
    pins_tb.chg_active <= 1'b0;
    tdone("monitor");
    wr(pers_pkg::IDX_CHG_CFG2, 8'h01);
    wr(pers_pkg::IDX_CHG_CFG3, 8'h06);
    wr(pers_pkg::IDX_IRQ_MASK0, 8'h00);
    cyc(3);
    `CHK("cmp cfg", 3'b111, {power.cell_cmp_en, power.cell_thr_sel})
    pins_tb.cell_below <= 1'b1;
    `WAITC(power.irq_n_oe, 8)
    `CHK("irq low", 1'b1, power.irq_n_oe)
    rdchk("cmp below", pers_pkg::IDX_CHG_CFG3, 8'h06);
    rdchk("flag", pers_pkg::IDX_IRQ_FLAG0, 8'h01);
    cyc(2);
    `CHK("irq released", 1'b0, power.irq_n_oe)
    wr(pers_pkg::IDX_CHG_CFG2, 8'h00);
    rdchk("cmp off", pers_pkg::IDX_CHG_CFG3, 8'h07);
    tdone("comparator");
    // release the button with hold-all set, then hand over to holds
    wr(pers_pkg::IDX_MISC_CTRL, 8'h20);
    press <= 1'b0;
    bounce <= 4'h0;
    cyc(DEB + 10);
    `CHK("hold all", 2'b11, {power.buck_enable, power.linreg_enable})
    pins_tb.buck_hold_in <= 1'b1;
    wr(pers_pkg::IDX_LINREG_V, 8'h95);
    wr(pers_pkg::IDX_MISC_CTRL, 8'h00);
    cyc(6);
    `CHK("pin and bit hold", 2'b11, {power.buck_enable, power.linreg_enable})
    `CHK("linreg code", 6'h15, power.linreg_vsel)
    wr(pers_pkg::IDX_LINREG_V, 8'h15);
    cyc(6);
    `CHK("buck hold only", 2'b10, {power.buck_enable, power.linreg_enable})
    rdchk("reload", pers_pkg::IDX_BUCK_V, 8'h16);
    pins_tb.buck_hold_in <= 1'b0;
    cyc(6);
    `CHK("all off", 3'b000, {power.buck_enable, power.linreg_enable, power.ctrl_powered})
    pins_tb.linreg_hold_in <= 1'b1;
    cyc(6);
    `CHK("hold as enable", 2'b01, {power.buck_enable, power.linreg_enable})
    pins_tb.buck_hold_in <= 1'b1;
    cyc(6);
    pins_tb.linreg_overtemp <= 1'b1;
    `WAITC(!power.linreg_enable, 6)
    `CHK("thermal trip", 3'b000, {power.buck_enable, power.linreg_enable, power.linreg_tmon_en})
    pins_tb.linreg_overtemp <= 1'b0;
    cyc(6);
    pins_tb.rail_uvlo <= 1'b1;
    cyc(6);
    `CHK("lockout", 3'b001, {power.buck_enable, power.linreg_enable, power.reset_n_oe})
    pins_tb.rail_uvlo <= 1'b0;
    pins_tb.buck_hold_in <= 1'b0;
    pins_tb.linreg_hold_in <= 1'b0;
    tdone("holds");
    pins_tb.chg_overtemp <= 1'b1;
    cyc(6);
    `CHK("charger warm", 2'b10, {power.chg_current_reduce, power.chg_disable})
    pins_tb.chg_overhot <= 1'b1;
    cyc(6);
    `CHK("charger hot", 2'b11, {power.chg_current_reduce, power.chg_disable})
    pins_tb.charger_input_good <= 1'b1;
    cyc(RDLY + 10);
    `CHK("input good", 3'b110, {power.buck_enable, power.linreg_enable, power.reset_n_oe})
    pins_tb.linreg_pgood <= 1'b0;
    cyc(6);
    `CHK("power bad", 1'b1, power.reset_n_oe)
    pins_tb.linreg_pgood <= 1'b1;
    pins_tb.charger_input_good <= 1'b0;
    pins_tb.cell_present <= 1'b0;
    cyc(6);
    `CHK("input gone", 2'b00, {power.buck_enable, power.linreg_enable})
    pins_tb.cell_present <= 1'b1;
    pins_tb.linreg_hold_in <= 1'b1;
    cyc(8);
    `CHK("cell lost", 1'b0, power.linreg_enable)
    tdone("charger");
    // threshold variant: reset follows the comparator, released after the delay
    pins_tb.thr_below <= 1'b1;
    cyc(6);
    `CHK("threshold below", 1'b1, power_thr.reset_n_oe)
    pins_tb.thr_below <= 1'b0;
    cyc(RDLY - 5);
    `CHK("threshold hold", 1'b1, power_thr.reset_n_oe)
    `WAITC(!power_thr.reset_n_oe, 20)
    `CHK("threshold release", 1'b0, power_thr.reset_n_oe)
    tdone("threshold");
    reset <= 1'b1;
    cyc(2);
    `CHK("second reset", 3'b001, {power.buck_enable, power.linreg_enable, power.reset_n_oe})
    tdone("second reset");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
